// file: hw/abu_top.sv
// Address breakpoint unit: compare, break request, registers, interrupt
//
// Summary of operation
// - Raise break request when CPU program address equals 16-bit break address.
// - Break vectors to FFFC:FFFD in user mode, FEFC:FEFD in monitor mode.
// - Break loads instruction register with software interrupt opcode.
// - Break starts after current instruction; immediately if match on last cycle.
// - Return from interrupt inside break routine ends break state.
// - Software writing one to active bit triggers a break.
// - Enable bit 7 is read/write, gates matches, cleared by zero or reset.
// - Active bit set by match, readable, cleared by zero write or reset.
// - Address high at FE0C, low at FE0D, read/write, reset to zero.
// - Status/control at FE0E: enable bit 7, active bit 6, others zero.
// - Timer counters are frozen while a break is active.
// - Watchdog held disabled during break when high test voltage present.
// - Flags clearable during break only when clear enable bit is set.
// - Comparison continues in wait mode; wait flag marks wait exit by break.
// - In stop mode matches are ignored but an active-bit write still breaks; register contents unchanged by stop.
// - Only CPU-generated program counter addresses are compared.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "abu_defs.svh"
module abu_top (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [15:0]       wb_adr_i,
   input  wire logic [7:0]        wb_dat_i,
   input  wire logic              wb_sel_i,
   output logic                   wb_ack_o,
   output logic [7:0]             wb_dat_o,
   input  wire abu_pkg::abu_cpu_type cpu_i,
   input  wire logic              monitor_mode,
   input  wire logic              high_test_voltage,
   input  wire logic              wait_mode,
   input  wire logic              stop_mode,
   input  wire logic              break_flag_clear_enable,
   output abu_pkg::abu_inject_type inject_o,
   output logic                   breakpoint_request,
   output logic                   timer_freeze,
   output logic                   watchdog_hold,
   output logic                   flag_clear_allow,
   output logic                   break_wait_flag,
   output logic                   irq
);
   import abu_pkg::*;

   logic [7:0]          addr_high_q;
   logic [7:0]          addr_low_q;
   logic                enable_q;
   logic                active_q;
   logic [`ABU_EVT_BITS-1:0] irq_status_q;
   logic [`ABU_EVT_BITS-1:0] irq_mask_q;
   abu_state_type       state_q;
   abu_inject_type      inject_q;
   logic                request_q;
   logic                freeze_q;
   logic                wd_hold_q;
   logic                clr_allow_q;
   logic                bw_q;
   logic                irq_q;
   logic                wr_stb;
   logic [15:0]         acc_addr;
   logic [7:0]          acc_data;
   logic [7:0]          rd_data;
   logic                match;
   logic                soft_break;
   logic                start_now;
   logic [`ABU_EVT_BITS-1:0] evt;
   logic                wr_ctrl;

   // ----------------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------------
   abu_wb_slave #(
      .AW (16)
   ) u_slave (
      .clk      (clk),
      .reset_n  (reset_n),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_dat_i (wb_dat_i),
      .wb_sel_i (wb_sel_i),
      .rd_data  (rd_data),
      .wb_ack_o (wb_ack_o),
      .wb_dat_o (wb_dat_o),
      .wr_stb   (wr_stb),
      .acc_addr (acc_addr),
      .acc_data (acc_data)
   );

   always_comb begin
      unique case (acc_addr)
         `ABU_OFF_ADDR_HIGH: rd_data = addr_high_q;
         `ABU_OFF_ADDR_LOW:  rd_data = addr_low_q;
         `ABU_OFF_STAT_CTRL: rd_data = {enable_q, active_q, 6'h00};
         `ABU_OFF_IRQ_STATUS: rd_data = {5'h00, irq_status_q};
         `ABU_OFF_IRQ_MASK:  rd_data = {5'h00, irq_mask_q};
         default:            rd_data = 8'h00;
      endcase
   end

   assign wr_ctrl = wr_stb && (acc_addr == `ABU_OFF_STAT_CTRL);

   // ----------------------------------------------------------------------
   // Break address registers
   // ----------------------------------------------------------------------
   // Stop mode touches none of these; only reset and writes do
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_high_q <= `ABU_RST_BYTE;
         addr_low_q  <= `ABU_RST_BYTE;
      end else if (wr_stb) begin
         if (acc_addr == `ABU_OFF_ADDR_HIGH) begin
            addr_high_q <= acc_data;
         end
         if (acc_addr == `ABU_OFF_ADDR_LOW) begin
            addr_low_q <= acc_data;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Compare
   // ----------------------------------------------------------------------
   // Comparison is off in stop; wait mode keeps it running
   assign match = enable_q && !stop_mode
                  && cpu_i.from_cpu && cpu_i.pc_fetch
                  && (cpu_i.addr == {addr_high_q, addr_low_q});
   assign soft_break = wr_ctrl && acc_data[`ABU_BIT_ACTIVE];

   // ----------------------------------------------------------------------
   // Enable and active bits
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         enable_q <= 1'b0;
      end else if (wr_ctrl) begin
         enable_q <= acc_data[`ABU_BIT_ENABLE];
      end
   end

   // A match in the same cycle as a zero write keeps the bit set
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         active_q <= 1'b0;
      end else if (match || soft_break) begin
         active_q <= 1'b1;
      end else if (wr_ctrl) begin
         active_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Break sequencing
   // ----------------------------------------------------------------------
   // No boundary counts in stop, so a trigger there waits in pending
   assign start_now = cpu_i.last_cycle && !stop_mode;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ABU_IDLE;
      end else if (stop_mode && state_q == ABU_PENDING) begin
         state_q <= ABU_PENDING;
      end else begin
         unique case (state_q)
            ABU_IDLE: begin
               if (match || soft_break) begin
                  state_q <= start_now ? ABU_IN_BREAK : ABU_PENDING;
               end
            end
            ABU_PENDING: begin
               if (start_now) begin
                  state_q <= ABU_IN_BREAK;
               end
            end
            ABU_IN_BREAK: begin
               if (cpu_i.rti_done) begin
                  state_q <= ABU_IDLE;
               end
            end
         endcase
      end
   end

   // Request stays up from the trigger until the routine returns
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         request_q <= 1'b0;
      end else if (match || soft_break) begin
         request_q <= 1'b1;
      end else if (state_q == ABU_IN_BREAK && cpu_i.rti_done) begin
         request_q <= 1'b0;
      end
   end

   // Opcode injection is a one-cycle pulse at the instruction boundary
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         inject_q <= '0;
      end else begin
         inject_q.inject_swi <= start_now && !stop_mode &&
            (state_q == ABU_PENDING ||
             (state_q == ABU_IDLE && (match || soft_break)));
         inject_q.opcode <= `ABU_OPC_SWI;
         inject_q.vector <= monitor_mode ? `ABU_VEC_MONITOR
                                         : `ABU_VEC_USER;
      end
   end

   // ----------------------------------------------------------------------
   // Side effects of the break state
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         freeze_q    <= 1'b0;
         wd_hold_q   <= 1'b0;
         clr_allow_q <= 1'b1;
      end else begin
         freeze_q    <= (state_q == ABU_IN_BREAK);
         wd_hold_q   <= (state_q == ABU_IN_BREAK) && high_test_voltage;
         clr_allow_q <= (state_q != ABU_IN_BREAK)
                        || break_flag_clear_enable;
      end
   end

   // Set on a break leaving wait; cleared once the routine returns
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bw_q <= 1'b0;
      end else if (wait_mode && (match || soft_break)) begin
         bw_q <= 1'b1;
      end else if (state_q == ABU_IN_BREAK && cpu_i.rti_done) begin
         bw_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------------
   assign evt = {wait_mode && match, soft_break, match};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_status_q <= '0;
      end else if (wr_stb && acc_addr == `ABU_OFF_IRQ_STATUS) begin
         // New events win over a write-one clear in the same cycle
         irq_status_q <= (irq_status_q & ~acc_data[`ABU_EVT_BITS-1:0]) | evt;
      end else begin
         irq_status_q <= irq_status_q | evt;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_mask_q <= '0;
      end else if (wr_stb && acc_addr == `ABU_OFF_IRQ_MASK) begin
         irq_mask_q <= acc_data[`ABU_EVT_BITS-1:0];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_status_q & irq_mask_q);
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign inject_o           = inject_q;
   assign breakpoint_request = request_q;
   assign timer_freeze       = freeze_q;
   assign watchdog_hold      = wd_hold_q;
   assign flag_clear_allow   = clr_allow_q;
   assign break_wait_flag    = bw_q;
   assign irq                = irq_q;
endmodule : abu_top

// file: hw/abu_defs.svh
// Register offsets, field positions, reset values and vectors of the breakpoint unit
`ifndef ABU_DEFS_SVH
`define ABU_DEFS_SVH
`define ABU_OFF_ADDR_HIGH   16'hFE0C
`define ABU_OFF_ADDR_LOW    16'hFE0D
`define ABU_OFF_STAT_CTRL   16'hFE0E
`define ABU_OFF_IRQ_STATUS  16'hFE10
`define ABU_OFF_IRQ_MASK    16'hFE11
`define ABU_BIT_ENABLE      7
`define ABU_BIT_ACTIVE      6
`define ABU_RST_BYTE        8'h00
`define ABU_VEC_USER        16'hFFFC
`define ABU_VEC_MONITOR     16'hFEFC
`define ABU_OPC_SWI         8'h83
`define ABU_EVT_MATCH       0
`define ABU_EVT_SOFT        1
`define ABU_EVT_WAIT_EXIT   2
`define ABU_EVT_BITS        3
`endif

// file: hw/abu_pkg.sv
// Types shared by the breakpoint unit files
package abu_pkg;
   typedef struct packed {
      logic [15:0] addr;
      logic        pc_fetch;
      logic        last_cycle;
      logic        rti_done;
      logic        from_cpu;
   } abu_cpu_type;

   typedef struct packed {
      logic        inject_swi;
      logic [15:0] vector;
      logic [7:0]  opcode;
   } abu_inject_type;

   typedef enum logic [1:0] {
      ABU_IDLE,
      ABU_PENDING,
      ABU_IN_BREAK
   } abu_state_type;
endpackage : abu_pkg

// file: hw/abu_wb_slave.sv
// Classic Wishbone byte slave front end for the breakpoint unit
`timescale 1ns/100ps
module abu_wb_slave #(
   parameter int AW = 16
) (
   input  wire logic          clk,
   input  wire logic          reset_n,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [AW-1:0] wb_adr_i,
   input  wire logic [7:0]    wb_dat_i,
   input  wire logic          wb_sel_i,
   input  wire logic [7:0]    rd_data,
   output logic               wb_ack_o,
   output logic [7:0]         wb_dat_o,
   output logic               wr_stb,
   output logic [AW-1:0]      acc_addr,
   output logic [7:0]         acc_data
);
   logic req;

   initial begin
      if (AW < 16) $error("abu_wb_slave needs at least 16 address bits");
   end

   // ----------------------------------------------------------------------
   // Single-cycle answer
   // ----------------------------------------------------------------------
   assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign acc_addr = wb_adr_i;
   assign acc_data = wb_dat_i;
   // Write pulses only on the edge the ack is given, so it fires once
   assign wr_stb   = req && wb_we_i && wb_sel_i;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 8'h00;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            wb_dat_o <= wb_sel_i ? rd_data : 8'h00;
         end
      end
   end
endmodule : abu_wb_slave

// file: verif/abu_top_properties.sv
// Concurrent checks on the breakpoint unit ports
`timescale 1ns/100ps
`include "abu_defs.svh"
module abu_top_properties (
   input wire logic                   clk,
   input wire logic                   reset_n,
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_ack_o,
   input wire abu_pkg::abu_cpu_type   cpu_i,
   input wire logic                   monitor_mode,
   input wire logic                   high_test_voltage,
   input wire logic                   wait_mode,
   input wire logic                   stop_mode,
   input wire logic                   break_flag_clear_enable,
   input wire abu_pkg::abu_inject_type inject_o,
   input wire logic                   breakpoint_request,
   input wire logic                   timer_freeze,
   input wire logic                   watchdog_hold,
   input wire logic                   flag_clear_allow,
   input wire logic                   break_wait_flag
);
   import abu_pkg::*;
   // ------------------------------------------------------------------
   // Break entry, exit, side effects, low power and bus acknowledge
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_exit_seen;
      cpu_i.rti_done && timer_freeze && breakpoint_request;
   endsequence
   sequence s_exit_done;
      !breakpoint_request ##1 !timer_freeze;
   endsequence
   sequence s_ack_once;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   chk_exit_order: assert property (s_exit_seen |=> s_exit_done)
      else $error("break did not end after return");
   chk_vector_mode: assert property (inject_o.inject_swi |->
      inject_o.vector == ($past(monitor_mode) ? `ABU_VEC_MONITOR
                                              : `ABU_VEC_USER))
      else $error("break vector does not follow the mode");
   chk_swi_opcode: assert property (inject_o.inject_swi |->
      inject_o.opcode == `ABU_OPC_SWI && breakpoint_request)
      else $error("injected opcode wrong");
   chk_inject_boundary: assert property (inject_o.inject_swi |->
      $past(cpu_i.last_cycle) ##1 !inject_o.inject_swi)
      else $error("injection not on an instruction boundary");
   chk_freeze_follow: assert property (
      inject_o.inject_swi |=> timer_freeze)
      else $error("timer not frozen in break");
   chk_watchdog_gate: assert property (
      watchdog_hold == (timer_freeze && $past(high_test_voltage)))
      else $error("watchdog hold wrong");
   chk_flag_protect: assert property (
      flag_clear_allow == !(timer_freeze && !$past(break_flag_clear_enable)))
      else $error("flag clear permission wrong");
   chk_stop_quiet: assert property (
      stop_mode && !breakpoint_request && !wb_cyc_i |=> !breakpoint_request)
      else $error("break raised in stop mode");
   chk_wait_record: assert property ($rose(break_wait_flag) |->
      breakpoint_request && $past(wait_mode))
      else $error("wait flag set without break in wait");
   chk_ack_single: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_once)
      else $error("bus acknowledge not a single pulse");
endmodule : abu_top_properties

bind abu_top abu_top_properties u_chk (.*);

// file: verif/abu_cpu_model.sv
// Behavioural CPU side: fetches, instruction ends and return from break
`timescale 1ns/100ps
module abu_cpu_model (
   input  wire logic          clk,
   input  wire logic          reset_n,
   input  wire logic          fetch_req,
   input  wire logic [15:0]   fetch_addr,
   input  wire logic          fetch_cpu,
   input  wire logic          lc_now,
   input  wire logic          slow,
   input  wire logic          inject_swi,
   output abu_pkg::abu_cpu_type cpu_o
);
   import abu_pkg::*;
   logic [3:0]  rti_q;
   logic [1:0]  lc_q;
   logic [15:0] idle_q;
   // Idle address walks every cycle so a stale match can never linger
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cpu_o <= '0;
         rti_q <= 4'h0;
         lc_q <= 2'h0;
         idle_q <= 16'h0F0F;
      end else begin
         idle_q <= idle_q + 16'h1357;
         cpu_o.rti_done <= (rti_q == 4'h1);
         if (inject_swi) rti_q <= slow ? 4'hC : 4'h3;
         else if (rti_q != 4'h0) rti_q <= rti_q - 4'h1;
         if (fetch_req) begin
            cpu_o.addr <= fetch_addr;
            cpu_o.pc_fetch <= 1'b1;
            cpu_o.from_cpu <= fetch_cpu;
            cpu_o.last_cycle <= lc_now;
            lc_q <= lc_now ? 2'h0 : 2'h2;
         end else begin
            cpu_o.addr <= idle_q;
            cpu_o.pc_fetch <= 1'b0;
            cpu_o.from_cpu <= 1'b1;
            cpu_o.last_cycle <= (lc_q == 2'h1) || (lc_q == 2'h0 && idle_q[0]);
            if (lc_q != 2'h0) lc_q <= lc_q - 2'h1;
         end
      end
   end
endmodule : abu_cpu_model

// file: verif/abu_top_bench.sv
// Self-checking bench for the address breakpoint unit
`timescale 1ns/100ps
`include "abu_defs.svh"
module abu_top_bench;
   import abu_pkg::*;
   typedef struct packed {
      logic        we;
      logic [15:0] a;
      logic [7:0]  d;
      logic [7:0]  e;
   } abu_row_type;
   logic clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_ack_o, irq;
   logic [15:0] wb_adr_i, fetch_addr;
   logic [7:0] wb_dat_i, wb_dat_o, rd;
   logic monitor_mode, high_test_voltage, wait_mode, stop_mode, slow;
   logic break_flag_clear_enable, breakpoint_request, timer_freeze;
   logic watchdog_hold, flag_clear_allow, break_wait_flag;
   logic fetch_req, fetch_cpu, lc_now;
   abu_cpu_type cpu_i;
   abu_inject_type inject_o;
   int fails, n_compared;
   abu_row_type rows [17] = '{'{0,16'hFE0C,0,0}, '{0,16'hFE0D,0,0},
      '{0,16'hFE0E,0,0}, '{0,16'hFE10,0,0}, '{0,16'hFE11,0,0},
      '{1,16'hFE0C,8'h12,0}, '{1,16'hFE0D,8'h34,0}, '{0,16'hFE0C,0,8'h12},
      '{0,16'hFE0D,0,8'h34}, '{1,16'hFE0E,8'h3F,0}, '{0,16'hFE0E,0,0},
      '{1,16'hFE0E,8'h80,0}, '{0,16'hFE0E,0,8'h80}, '{1,16'hFE0F,8'hAA,0},
      '{0,16'hFE0F,0,0}, '{1,16'hFE11,8'h01,0}, '{0,16'hFE11,0,8'h01}};
   abu_top dut (.*);
   abu_cpu_model u_cpu (.clk, .reset_n, .fetch_req, .fetch_addr, .fetch_cpu,
      .lc_now, .slow, .inject_swi(inject_o.inject_swi), .cpu_o(cpu_i));
   always #10 clk = ~clk;
   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic chk_val(input string nm, input logic [15:0] e, g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_val
   task automatic chk_bit(input string nm, input logic e, g);
      chk_val(nm, {15'h0, e}, {15'h0, g});
   endtask : chk_bit
   task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // Ack and read data are taken at the rising edge that sees ack high
      do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 40);
      if (wb_ack_o !== 1'b1) chk_bit("ack", 1'b1, wb_ack_o);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic fetch(input logic [15:0] a, input logic c, lc);
      @(posedge clk);
      fetch_addr <= a;
      fetch_cpu <= c;
      lc_now <= lc;
      fetch_req <= 1'b1;
      @(posedge clk);
      fetch_req <= 1'b0;
   endtask : fetch
   task automatic wait_for(input int k, input logic lvl);
      int n;
      n = 0;
      while ((k == 0 ? inject_o.inject_swi : breakpoint_request) !== lvl
             && n < 40) begin @(negedge clk); n++; end
      chk_bit("wait", lvl, k == 0 ? inject_o.inject_swi : breakpoint_request);
   endtask : wait_for
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   initial begin
      #(20 * 6000);
      fails++;
      conclude();
   end
   initial begin
      {clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, fetch_req, fetch_cpu} = '0;
      {monitor_mode, high_test_voltage, wait_mode, stop_mode, slow} = '0;
      {break_flag_clear_enable, lc_now, wb_sel_i} = 3'b001;
      {wb_adr_i, wb_dat_i, fetch_addr} = '0;
      fails = 0;
      n_compared = 0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      foreach (rows[i]) begin
         wb(rows[i].we, rows[i].a, rows[i].d);
         if (!rows[i].we) chk_val("register", rows[i].e, rd);
      end
      $display("test registers done");
      for (int i = 0; i < 2; i++) begin
         monitor_mode <= i[0];
         slow <= i[0];
         fetch(16'h1234, 1'b1, i == 0);
         // The fetch is on the bus one cycle; the request follows it
         repeat (2) @(negedge clk);
         chk_bit("request", 1'b1, breakpoint_request);
         chk_bit("early inject", i == 0, inject_o.inject_swi);
         wait_for(0, 1'b1);
         chk_val("vector", i ? `ABU_VEC_MONITOR : `ABU_VEC_USER,
                 inject_o.vector);
         chk_val("opcode", `ABU_OPC_SWI, inject_o.opcode);
         @(negedge clk);
         chk_bit("freeze", 1'b1, timer_freeze);
         wait_for(1, 1'b0);
         @(negedge clk);
         chk_bit("freeze off", 1'b0, timer_freeze);
         chk_bit("irq", 1'b1, irq);
         wb(0, 16'hFE0E, 0);
         chk_val("active", 8'hC0, rd);
         wb(1, 16'hFE0E, 8'h80);
         wb(1, 16'hFE10, 8'h01);
         wb(0, 16'hFE0E, 0);
         chk_val("active clear", 8'h80, rd);
         chk_bit("irq clear", 1'b0, irq);
      end
      $display("test address break done");
      fetch(16'h1234, 1'b0, 1'b1);
      repeat (3) @(negedge clk);
      chk_bit("other master", 1'b0, breakpoint_request);
      wb(1, 16'hFE0E, 8'h00);
      fetch(16'h1234, 1'b1, 1'b1);
      repeat (3) @(negedge clk);
      chk_bit("disabled", 1'b0, breakpoint_request);
      $display("test ignored matches done");
      @(posedge clk);
      high_test_voltage <= 1'b1;
      break_flag_clear_enable <= 1'b0;
      wb(1, 16'hFE0E, 8'h40);
      wait_for(0, 1'b1);
      repeat (2) @(negedge clk);
      chk_bit("watchdog", 1'b1, watchdog_hold);
      chk_bit("flag clear", 1'b0, flag_clear_allow);
      wait_for(1, 1'b0);
      wb(0, 16'hFE10, 0);
      chk_val("soft status", 8'h02, rd);
      wb(1, 16'hFE10, 8'h02);
      high_test_voltage <= 1'b0;
      $display("test soft break done");
      wb(1, 16'hFE0E, 8'h80);
      stop_mode <= 1'b1;
      fetch(16'h1234, 1'b1, 1'b1);
      repeat (3) @(negedge clk);
      chk_bit("stop", 1'b0, breakpoint_request);
      @(posedge clk);
      stop_mode <= 1'b0;
      wb(0, 16'hFE0C, 0);
      chk_val("kept", 8'h12, rd);
      wait_mode <= 1'b1;
      fetch(16'h1234, 1'b1, 1'b1);
      wait_for(0, 1'b1);
      @(negedge clk);
      chk_bit("wait flag", 1'b1, break_wait_flag);
      wait_for(1, 1'b0);
      @(negedge clk);
      chk_bit("wait flag off", 1'b0, break_wait_flag);
      @(posedge clk);
      wait_mode <= 1'b0;
      wb(0, 16'hFE10, 0);
      chk_val("wait status", 8'h05, rd);
      $display("test low power done");
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      wb(0, 16'hFE0C, 0);
      chk_val("reset high", 8'h00, rd);
      $display("test second reset done");
      conclude();
   end
endmodule : abu_top_bench
